// file: core/smc_pkg.sv
`default_nettype none
// Shared constants for the supply monitor control block
package smc_pkg;
   // Bus geometry
   localparam int unsigned SMC_ADDR_W = 16;
   localparam int unsigned SMC_DATA_W = 32;
   localparam int unsigned SMC_REG_W = 8;
   localparam int unsigned SMC_CHANS = 2;

   // Register indices; the byte address is four times the index
   localparam logic [SMC_ADDR_W-1:0] SMC_CTRL_IDX = 16'h0FC7;
   localparam logic [SMC_ADDR_W-1:0] SMC_STAT_IDX = 16'h0FC8;
   localparam logic [SMC_ADDR_W-1:0] SMC_CTRL_ADDR = 16'h3F1C;
   localparam logic [SMC_ADDR_W-1:0] SMC_STAT_ADDR = 16'h3F20;

   // Control register field positions
   localparam int unsigned SMC_C1_EN_BIT = 0;
   localparam int unsigned SMC_C1_MOD_BIT = 1;
   localparam int unsigned SMC_C2_EN_BIT = 2;
   localparam int unsigned SMC_C2_MOD_BIT = 3;
   localparam int unsigned SMC_SPARE_LO_BIT = 4;
   localparam int unsigned SMC_SPARE_HI_BIT = 5;

   // Writable bits (5:0); bits 7:6 always read zero
   localparam logic [SMC_REG_W-1:0] SMC_CTRL_WMASK = 8'h3F;
   localparam logic [SMC_REG_W-1:0] SMC_CTRL_RESET = 8'h00;

   // Status register field positions
   localparam int unsigned SMC_ST_BELOW_LSB = 0;
   localparam int unsigned SMC_ST_RST_LSB = 2;

   // Synchroniser depth for comparator levels
   localparam int unsigned SMC_SYNC_STAGES = 2;
endpackage
`default_nettype wire

// file: core/smc_sync.sv
`default_nettype none
// Two flop level synchroniser, one lane per bit
module smc_sync #(
   parameter int unsigned WIDTH = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   // First stage; only the second stage may look at it
   logic [WIDTH-1:0] meta_q;

   // Both stages clear on reset to a constant
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= '0;
         sync_out <= '0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule
`default_nettype wire

// file: core/smc_top.sv
`default_nettype none
// Behaviour
// - chan2 mode picks interrupt or chan2 reset
// - chan2 enable gates chan2 detection
// - chan1 mode picks interrupt or reset
// - chan1 enable gates chan1 detection
// - control cleared only by presetn
// - bits 7 and 6 read zero
// - bit map: c2 mode, c2 en, c1 mode, c1 en
// - reset held while supply stays low
// - enabling while low responds at once
module smc_top
   import smc_pkg::*;
#(
   parameter int unsigned ADDR_W = SMC_ADDR_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [SMC_DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [SMC_DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [SMC_CHANS-1:0] chan_below_threshold,
   output logic low_supply_irq,
   output logic chan1_detect_reset,
   output logic chan2_detect_reset
);

   // Control register; only presetn clears it, so a detect reset
   // raised here never wipes the setting that caused it
   logic [SMC_REG_W-1:0] supply_monitor_control_q;

   // Synchronised comparator levels
   logic [SMC_CHANS-1:0] below_sync;

   // Per channel enable and mode, unpacked from the register
   logic [SMC_CHANS-1:0] chan_monitor_enable;
   logic [SMC_CHANS-1:0] chan_response_select;

   // Per channel qualified conditions
   logic [SMC_CHANS-1:0] irq_cond;
   logic [SMC_CHANS-1:0] rst_cond;

   // Previous interrupt condition, for the rising edge
   logic [SMC_CHANS-1:0] irq_cond_q;

   // Detect reset levels, registered
   logic [SMC_CHANS-1:0] rst_q;

   // APB decode helpers
   logic access; // Access phase of a selected transfer
   logic hit_ctrl; // Address matches the control word
   logic hit_stat; // Address matches the status word
   logic commit; // Edge on which the transfer completes
   // Load strobe for read data, one cycle ahead of pready
   logic rd_load;
   // Control write that lands on this edge
   logic wr_ctrl;
   // Read data ahead of its output flop
   logic [SMC_DATA_W-1:0] rdata_d;

   // Comparator outputs are asynchronous to pclk. Two stages keep a
   // level caught mid-change from reaching the response logic; the
   // price is two cycles of extra latency on every detection.
   smc_sync #(
      .WIDTH(SMC_CHANS)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(chan_below_threshold),
      .sync_out(below_sync)
   );

   // Field unpack; index 0 is channel 1, index 1 is channel 2
   // Bits 5:4 are stored and feed only the read mux
   always_comb begin
      chan_monitor_enable[0] = supply_monitor_control_q[SMC_C1_EN_BIT];
      chan_monitor_enable[1] = supply_monitor_control_q[SMC_C2_EN_BIT];
      chan_response_select[0] =
         supply_monitor_control_q[SMC_C1_MOD_BIT];
      chan_response_select[1] =
         supply_monitor_control_q[SMC_C2_MOD_BIT];
   end

   // Channel qualification, one lane per channel. The comparators
   // have no hysteresis, so near the threshold these conditions can
   // toggle often; nothing here filters that.
   for (genvar ch = 0; ch < SMC_CHANS; ch++) begin : g_chan
      // Disabled channel produces neither response
      // Interrupt mode: mode bit low
      assign irq_cond[ch] = chan_monitor_enable[ch] & below_sync[ch]
         & ~chan_response_select[ch];
      // Reset mode: mode bit high
      assign rst_cond[ch] = chan_monitor_enable[ch] & below_sync[ch]
         & chan_response_select[ch];
   end

   // Detect reset follows the level for as long as it lasts.
   // It is not stretched: it drops three edges after the supply recovers,
   // or on the next edge after software clears the enable or the mode.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_q <= '0;
      end else begin
         rst_q <= rst_cond;
      end
   end

   // Drive reset outputs from their flops; plain wiring, no gates,
   // so each output is a flop output in all but name
   always_comb begin
      chan1_detect_reset = rst_q[0];
      chan2_detect_reset = rst_q[1];
   end

   // Track the interrupt condition for edge detection.
   // Cleared on reset, so a channel already low after reset still
   // shows as a new edge once it is enabled.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_cond_q <= '0;
      end else begin
         irq_cond_q <= irq_cond;
      end
   end

   // Shared interrupt: one pulse when any channel newly qualifies.
   // Enabling a channel that is already low counts as a new edge,
   // so the request comes out without waiting for another crossing.
   // Limitation: channels qualifying in the same cycle merge into
   // one pulse; software reads the status word to tell them apart.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_supply_irq <= 1'b0;
      end else begin
         low_supply_irq <= |(irq_cond & ~irq_cond_q);
      end
   end

   // APB decode
   // Full address compare, so no alias of a register exists
   always_comb begin
      access = psel & penable;
      hit_ctrl = (paddr == SMC_CTRL_ADDR[ADDR_W-1:0]);
      hit_stat = (paddr == SMC_STAT_ADDR[ADDR_W-1:0]);
      // Transfer completes on the edge where pready is seen high
      commit = access & pready;
      // Read data is loaded in the first access cycle only
      rd_load = access & ~pready & ~pwrite;
      // A write with pstrb[0] low is dropped without an error
      wr_ctrl = commit & pwrite & hit_ctrl & pstrb[0];
   end

   // Read mux; reserved and unmapped data read as zero
   // Status word: synced levels in bits 1:0, resets in bits 3:2
   always_comb begin
      rdata_d = '0;
      if (hit_ctrl) begin
         rdata_d[SMC_REG_W-1:0] =
            supply_monitor_control_q & SMC_CTRL_WMASK;
      end else if (hit_stat) begin
         rdata_d[SMC_ST_BELOW_LSB +: SMC_CHANS] = below_sync;
         rdata_d[SMC_ST_RST_LSB +: SMC_CHANS] = rst_q;
      end
   end

   // One wait state per access keeps all outputs registered
   // Trade-off: each access costs a cycle more than a zero-wait
   // slave, but pready, prdata and pslverr all leave from flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= access & ~pready;
      end
   end

   // Read data captured alongside pready
   // Writes never load it, so the bus shows zero outside reads
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (rd_load) begin
         prdata <= rdata_d;
      end else if (commit) begin
         // Drop stale data once the transfer is over
         prdata <= '0;
      end
   end

   // Unmapped address, or a write to the read-only status word
   // It rises with pready and falls with it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else if (access & ~pready) begin
         // Decided in the first access cycle, shown with pready
         pslverr <= ~(hit_ctrl | (hit_stat & ~pwrite));
      end else begin
         pslverr <= 1'b0;
      end
   end

   // Control register write; byte lane 0 holds the whole field.
   // Bits 5:4 store what is written even though software should
   // only ever write zero there; only the read mux reads them back.
   // A detect reset raised by this block never reaches this flop.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         supply_monitor_control_q <= SMC_CTRL_RESET;
      end else if (wr_ctrl) begin
         supply_monitor_control_q <=
            pwdata[SMC_REG_W-1:0] & SMC_CTRL_WMASK;
      end
   end

endmodule
`default_nettype wire

// file: testbench/smc_monitor.sv
`default_nettype none
// Port watcher for the supply monitor control block
module smc_monitor
   import smc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [SMC_DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic [SMC_CHANS-1:0] chan_below_threshold,
   input wire logic low_supply_irq,
   input wire logic chan1_detect_reset,
   input wire logic chan2_detect_reset
);
   timeunit 1ns;
   timeprecision 100ps;
   // One domain, so clock and reset are given once
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_one_wait: assert property (psel && penable &&
      !$past(psel && penable) |=> pready) else $error("late pready");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready too long");
   a_rdata_idle: assert property (!pready |-> prdata == '0)
      else $error("prdata not idle");
   a_top_bits_zero: assert property (pready |-> prdata[31:6] == '0)
      else $error("upper bits set");
   a_c1_sync_cause: assert property ($rose(chan1_detect_reset) |->
      $past(chan_below_threshold[0], 3)) else $error("early reset 1");
   a_c2_sync_cause: assert property ($rose(chan2_detect_reset) |->
      $past(chan_below_threshold[1], 3)) else $error("early reset 2");
   // Dropping is legal only when the level went away or a transfer completed
   a_c1_reset_held: assert property ($fell(chan1_detect_reset) |->
      !$past(chan_below_threshold[0], 3) || $past(pready) ||
      $past(pready, 2)) else $error("reset 1 dropped");
   a_irq_cause: assert property (low_supply_irq |->
      $past(chan_below_threshold, 3) != '0) else $error("stray irq");
endmodule
bind smc_top smc_monitor u_mon (
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .prdata(prdata),
   .pready(pready),
   .chan_below_threshold(chan_below_threshold),
   .low_supply_irq(low_supply_irq),
   .chan1_detect_reset(chan1_detect_reset),
   .chan2_detect_reset(chan2_detect_reset)
);
`default_nettype wire

// file: testbench/smc_cmp_model.sv
`default_nettype none
// Comparator pair; levels change only on the clock, like a slow supply
module smc_cmp_model (
   input wire logic pclk,
   input wire logic [1:0] want_below,
   output logic [1:0] chan_below_threshold
);
   timeunit 1ns;
   timeprecision 100ps;
   // One flop of delay stands in for the analogue settling
   always_ff @(posedge pclk) begin
      chan_below_threshold <= want_below;
   end
endmodule
`default_nettype wire

// file: testbench/test_smc_top.sv
`default_nettype none
// Register and response tests for the supply monitor control block
module test_smc_top
   import smc_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
   logic [15:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, r, ic;
   logic [3:0] pstrb = 4'hF;
   logic pready, pslverr, low_supply_irq, c1r, c2r;
   logic [1:0] want = 2'h0, below;
   int fails = 0, num_checks = 0;
   smc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .chan_below_threshold(below), .low_supply_irq(low_supply_irq),
      .chan1_detect_reset(c1r), .chan2_detect_reset(c2r));
   smc_cmp_model cmp (.pclk(pclk), .want_below(want),
      .chan_below_threshold(below));
   always #12.5 pclk = ~pclk;
   // One APB transfer; holds the request until pready is seen high,
   // only the watchdog ends a wait that never completes
   task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task chk(input string s, input logic [31:0] x, input logic [31:0] g);
      num_checks++;
      if (g !== x) begin
         fails++;
         $display("Error %s expected %h seen %h", s, x, g);
      end
   endtask
   // Count irq pulses over a window long enough for the sync path,
   // then step to a rising edge so later stimulus lands on one
   task obs;
      ic = '0;
      repeat (8) begin
         @(negedge pclk);
         ic = ic + {31'h0, low_supply_irq};
      end
      @(posedge pclk);
   endtask
   task report_and_stop;
      $display("checks %0d errors %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Watchdog; the sequence needs about 150 cycles, this allows 4000
   initial begin
      #100000;
      fails++;
      report_and_stop;
   end
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, SMC_CTRL_ADDR, 32'h0);
      chk("ctrl rst", 32'h00, r);
      chk("ctrl no err", 32'h0, e);
      // Software keeps bits 5:4 at zero; bits 7:6 are offered as ones
      apb(1'b1, SMC_CTRL_ADDR, 32'hCF);
      apb(1'b0, SMC_CTRL_ADDR, 32'h0);
      chk("ctrl rw", 32'h0F, r);
      pstrb <= 4'hE;
      apb(1'b1, SMC_CTRL_ADDR, 32'h0);
      pstrb <= 4'hF;
      apb(1'b0, SMC_CTRL_ADDR, 32'h0);
      chk("strobe off", 32'h0F, r);
      apb(1'b0, 16'h3F24, 32'h0);
      chk("unmapped err", 32'h1, e);
      apb(1'b1, SMC_STAT_ADDR, 32'h0);
      chk("stat wr err", 32'h1, e);
      apb(1'b1, SMC_CTRL_ADDR, 32'h0);
      want <= 2'h1;
      obs;
      chk("off irq", 32'h0, ic);
      chk("off rst", 32'h0, c1r);
      apb(1'b1, SMC_CTRL_ADDR, 32'h03);
      obs;
      chk("c1 rst", 32'h1, c1r);
      chk("c1 no irq", 32'h0, ic);
      obs;
      chk("c1 held", 32'h1, c1r);
      apb(1'b0, SMC_CTRL_ADDR, 32'h0);
      chk("ctrl kept", 32'h03, r);
      want <= 2'h0;
      obs;
      chk("c1 release", 32'h0, c1r);
      apb(1'b1, SMC_CTRL_ADDR, 32'h0);
      want <= 2'h1;
      apb(1'b1, SMC_CTRL_ADDR, 32'h01);
      obs;
      chk("c1 irq", 32'h1, ic);
      want <= 2'h2;
      apb(1'b1, SMC_CTRL_ADDR, 32'h04);
      obs;
      chk("c2 irq", 32'h1, ic);
      chk("c2 no rst", 32'h0, c2r);
      // Channel 1 goes low too while it stays disabled
      want <= 2'h3;
      apb(1'b1, SMC_CTRL_ADDR, 32'h0C);
      obs;
      chk("c2 rst", 32'h1, c2r);
      chk("c2 rst no irq", 32'h0, ic);
      chk("c1 quiet", 32'h0, c1r);
      // Status: both levels below, only the channel 2 reset raised
      apb(1'b0, SMC_STAT_ADDR, 32'h0);
      chk("status", 32'h0B, r);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, SMC_CTRL_ADDR, 32'h0);
      chk("ctrl rst2", 32'h00, r);
      obs;
      chk("c2 off", 32'h0, c2r);
      chk("c1 off", 32'h0, c1r);
      chk("rst2 no irq", 32'h0, ic);
      report_and_stop;
   end
endmodule
`default_nettype wire
